// ---- src/rpg_pkg.sv ----
package rpg_pkg;
  // register offsets (byte addresses on the plain port)
  localparam logic [3:0] OFS_CLOCK_GATING = 4'h0;
  localparam logic [3:0] OFS_RESET_FLAGS  = 4'h1;
  localparam logic [3:0] OFS_SLEEP_CTRL   = 4'h2;
  localparam logic [3:0] OFS_ANALOG_CTRL  = 4'h3;
  localparam logic [3:0] OFS_STATUS       = 4'h4;
  // clock gating field positions
  localparam int GATE_CONVERTER_BIT  = 0;
  localparam int GATE_UART_ZERO_BIT  = 1;
  localparam int GATE_SERIAL_BIT     = 2;
  localparam int GATE_TIMER_ZERO_BIT = 3;
  localparam int GATE_TIMER_ONE_BIT  = 4;
  localparam int GATE_STAGE_ZERO_BIT = 5;
  localparam int GATE_STAGE_ONE_BIT  = 6;
  localparam int GATE_STAGE_TWO_BIT  = 7;
  localparam logic [7:0] CLOCK_GATING_RESET = 8'h00;
  // reset flag positions
  localparam int FLAG_SUPPLY_BIT   = 0;
  localparam int FLAG_EXTERNAL_BIT = 1;
  localparam int FLAG_BROWNOUT_BIT = 2;
  localparam int FLAG_WATCHDOG_BIT = 3;
  localparam logic [3:0] RESET_FLAGS_RESET = 4'h0;
  // sleep control: bit0 sleep active, bits 3:1 mode
  localparam int SLEEP_ACTIVE_BIT = 0;
  localparam logic [3:0] SLEEP_CTRL_RESET = 4'h0;
  // analog control: bit0 converter enable, bit1 comparator enable,
  // bit2 comparator on reference, bit3 watchdog enable
  localparam int CONV_EN_BIT  = 0;
  localparam int COMP_EN_BIT  = 1;
  localparam int COMP_REF_BIT = 2;
  localparam int WDOG_EN_BIT  = 3;
  localparam logic [3:0] ANALOG_CTRL_RESET = 4'h0;
  // brown-out fuse code meaning disabled
  localparam logic [2:0] BROWNOUT_OFF_CODE = 3'h7;
  // reset stretch time-out
  localparam int CLK_MHZ       = 10;
  localparam int TIMEOUT_US    = 65;
  localparam int TIMEOUT_CYC   = TIMEOUT_US * CLK_MHZ;
  localparam int CNT_W         = 16;

  typedef enum logic [2:0] {
    RPG_MODE_IDLE    = 3'h0,
    RPG_MODE_NOISE   = 3'h1,
    RPG_MODE_PWRDOWN = 3'h2,
    RPG_MODE_STANDBY = 3'h6
  } rpg_mode_t;

  typedef enum logic [1:0] {
    RPG_ST_HOLD    = 2'h0,
    RPG_ST_STRETCH = 2'h1,
    RPG_ST_RUN     = 2'h2
  } rpg_state_t;
endpackage

// ---- src/rpg_reset_power_control.sv ----
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
// Summary of operation
// RULE1: bit 3 gates timer zero power; running timer keeps behaving the same.
// RULE2: bit 2 stops serial peripheral clock; software reinitialises afterwards.
// RULE3: bit 1 stops UART clock; software reinitialises after re-enabling.
// RULE4: bit 0 stops converter clock; software disables converter first.
// RULE5: comparator cannot use converter input mux while converter clock gated.
// RULE6: enabled converter stays on in sleep; re-enable forces extended conversion.
// RULE7: comparator auto-off in deep sleep unless it uses the reference.
// RULE8: fuse-enabled brown-out detector stays active in every sleep mode.
// RULE9: reference on only when brown-out, comparator or converter need it; code also powers it whenever comparator is on, reference bit or not.
// RULE10: enabled watchdog keeps running in every sleep mode.
// RULE11: digital inputs off when I/O and converter clocks stop, wake pins kept.
// RULE12: debug fuse keeps main clock source running during sleep.
// RULE13: reset loads initial register values, then start at reset vector.
// RULE14: I/O ports reset immediately by any source, without clock; watchdog reset does not drive io_reset_n.
// RULE15: delay counter stretches internal reset after all sources inactive.
// RULE16: internal reset combines supply, pin, watchdog and brown-out sources.
// RULE17: watchdog reset only when watchdog enabled and period expired.
// RULE18: brown-out reset only while detector enabled and supply low.
// RULE19: supply-on reset held while supply low, reasserted without delay.
// RULE20: long low pin pulse resets without clock; other party holds it long.
// RULE21: pin rising starts delay counter; release after time-out.
// RULE22: bits 7..5 gate power stages, bit 4 timer one; all reset zero.
// RULE23: per-source reset flags; supply reset clears others; writing zero clears.
// RULE24: delay counter on free-running clock; terminal count is a parameter.
module rpg_reset_power_control
  import rpg_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input  wire logic       clk,               // free-running reset clock
  input  wire logic       rstn,              // async reset, active low
  input  wire logic       clk_en,            // freezes state when low
  input  wire logic [3:0] addr,              // register address
  input  wire logic [7:0] wdata,             // write data
  input  wire logic       wr,                // write strobe
  input  wire logic       rd,                // read strobe
  output logic      [7:0] rdata,             // read data, cycle after rd
  input  wire logic       supply_low,        // supply below on-reset threshold
  input  wire logic       reset_pin_n,       // external reset pin, active low
  input  wire logic       watchdog_expired,  // watchdog period expired pulse
  input  wire logic       supply_below_bot,  // brown-out comparator output
  input  wire logic [2:0] brownout_level_fuses, // brown-out level fuses
  input  wire logic       debug_enable_fuse, // on-chip debug fuse
  input  wire logic       wake_pin_needed,   // some pins watch wake-up
  output logic            io_reset_n,        // immediate port reset, active low
  output logic            core_reset_n,      // stretched internal reset
  output logic            cpu_clk_en,        // cpu clock enable
  output logic            io_clk_en,         // I/O clock enable
  output logic            conv_clk_en,       // converter clock enable
  output logic            timer0_clk_en,     // timer zero clock enable
  output logic            timer1_clk_en,     // timer one clock enable
  output logic            serial_clk_en,     // serial peripheral clock enable
  output logic            uart0_clk_en,      // uart clock enable
  output logic [2:0]      stage_clk_en,      // power stage clock enables
  output logic            comp_mux_allow,    // comparator may use converter mux
  output logic            conv_active,       // converter powered
  output logic            conv_extended,     // next conversion is extended
  output logic            comp_active,       // comparator powered
  output logic            ref_active,        // internal reference powered
  output logic            brownout_active,   // brown-out detector powered
  output logic            watchdog_active,   // watchdog running
  output logic            input_buf_en,      // general digital inputs on
  output logic            wake_buf_en,       // wake-up pin inputs on
  output logic            main_osc_en        // main oscillator running
);

  typedef struct packed {
    logic [1:0] pin_sync;
    logic [1:0] sup_sync;
    logic [1:0] bot_sync;
    rpg_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [7:0] gating;
    logic [3:0] flags;
    logic [3:0] sleep;
    logic [3:0] analog;
    logic       conv_was_on;
    logic       conv_ext;
    logic [7:0] rdata;
  } rpg_state_s_t;

  rpg_state_s_t r;
  rpg_state_s_t next_r;

  logic       pin_low;
  logic       sup_low;
  logic       bot_low;
  logic       bod_en;
  logic       wdog_rst;
  logic       bod_rst;
  logic       any_src;
  logic       sleeping;
  rpg_mode_t  mode;
  logic       deep;
  logic       conv_on;
  logic       comp_on;

  function automatic logic [CNT_W-1:0] term_count(input int cycles);
    term_count = (cycles > 1) ? CNT_W'(cycles - 1) : '0;
  endfunction

  assign pin_low = ~r.pin_sync[1];
  assign sup_low = r.sup_sync[1];
  assign bot_low = r.bot_sync[1];
  assign bod_en  = (brownout_level_fuses != BROWNOUT_OFF_CODE);
  // RULE17 watchdog qualified
  assign wdog_rst = watchdog_expired & r.analog[WDOG_EN_BIT];
  // RULE18 brownout qualified
  assign bod_rst = bod_en & bot_low;
  // RULE16 source combine
  assign any_src = sup_low | pin_low | wdog_rst | bod_rst;

  // RULE14 async port reset
  // RULE19 no delay reassert
  // RULE20 clockless pin reset
  assign io_reset_n = rstn & reset_pin_n & ~supply_low & ~(bod_en & supply_below_bot);
  // RULE13 held until release
  assign core_reset_n = (r.st == RPG_ST_RUN);

  assign sleeping = r.sleep[SLEEP_ACTIVE_BIT];
  assign mode     = rpg_mode_t'(r.sleep[3:1]);
  assign deep     = sleeping & (mode != RPG_MODE_IDLE) & (mode != RPG_MODE_NOISE);

  // RULE6 converter stays on in sleep
  assign conv_on = r.analog[CONV_EN_BIT];
  // RULE7 comparator auto-off
  assign comp_on = r.analog[COMP_EN_BIT] & (~deep | r.analog[COMP_REF_BIT]);

  always_comb begin
    next_r = r;
    // synchronisers: first stage read only by second
    next_r.pin_sync = {r.pin_sync[0], reset_pin_n};
    next_r.sup_sync = {r.sup_sync[0], supply_low};
    next_r.bot_sync = {r.bot_sync[0], supply_below_bot};
    // RULE15 delay stretch
    // RULE21 count after release
    // RULE24 parameter terminal count
    unique case (r.st)
      RPG_ST_HOLD: begin
        next_r.cnt = '0;
        if (!any_src) begin
          next_r.st = RPG_ST_STRETCH;
        end
      end
      RPG_ST_STRETCH: begin
        if (any_src) begin
          next_r.st  = RPG_ST_HOLD;
          next_r.cnt = '0;
        end else if (r.cnt >= term_count(TIMEOUT_CYCLES)) begin
          next_r.st = RPG_ST_RUN;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      RPG_ST_RUN: begin
        if (any_src) begin
          next_r.st = RPG_ST_HOLD;
        end
      end
      default: begin
        next_r.st = RPG_ST_HOLD;
      end
    endcase
    // RULE13 initial register values
    if (any_src) begin
      next_r.gating = CLOCK_GATING_RESET;
      next_r.sleep  = SLEEP_CTRL_RESET;
      next_r.analog = ANALOG_CTRL_RESET;
    end else if (wr && core_reset_n) begin
      unique case (addr)
        OFS_CLOCK_GATING: next_r.gating = wdata;
        OFS_SLEEP_CTRL:   next_r.sleep  = wdata[3:0];
        OFS_ANALOG_CTRL:  next_r.analog = wdata[3:0];
        default: ;
      endcase
    end
    // RULE23 writing zero clears
    if (wr && core_reset_n && addr == OFS_RESET_FLAGS) begin
      next_r.flags = r.flags & wdata[3:0];
    end
    // RULE23 set wins over clear
    if (sup_low) begin
      next_r.flags = 4'h1;
    end else begin
      if (pin_low) begin
        next_r.flags[FLAG_EXTERNAL_BIT] = 1'b1;
      end
      if (wdog_rst) begin
        next_r.flags[FLAG_WATCHDOG_BIT] = 1'b1;
      end
      if (bod_rst) begin
        next_r.flags[FLAG_BROWNOUT_BIT] = 1'b1;
      end
    end
    // RULE6 extended after re-enable
    next_r.conv_was_on = conv_on;
    if (conv_on && !r.conv_was_on) begin
      next_r.conv_ext = 1'b1;
    end else if (!conv_on) begin
      next_r.conv_ext = 1'b0;
    end
    next_r.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        OFS_CLOCK_GATING: next_r.rdata = r.gating;
        OFS_RESET_FLAGS:  next_r.rdata = {4'h0, r.flags};
        OFS_SLEEP_CTRL:   next_r.rdata = {4'h0, r.sleep};
        OFS_ANALOG_CTRL:  next_r.rdata = {4'h0, r.analog};
        OFS_STATUS:       next_r.rdata = {4'h0, ref_active, comp_on, conv_on, r.conv_ext};
        default:          next_r.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r          <= '0;
      // pin idles high; no false external reset after release
      r.pin_sync <= 2'h3;
      r.st       <= RPG_ST_HOLD;
      r.flags    <= RESET_FLAGS_RESET;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign rdata = r.rdata;

  // RULE22 stages and timer one
  // RULE1 timer zero gating
  // RULE2 serial clock gate
  // RULE3 uart clock gate
  // RULE4 converter clock gate
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_stage
      assign stage_clk_en[g] = ~r.gating[GATE_STAGE_ZERO_BIT + g] & ~deep;
    end
  endgenerate
  assign timer0_clk_en = ~r.gating[GATE_TIMER_ZERO_BIT] & ~deep;
  assign timer1_clk_en = ~r.gating[GATE_TIMER_ONE_BIT] & ~deep;
  assign serial_clk_en = ~r.gating[GATE_SERIAL_BIT] & io_clk_en;
  assign uart0_clk_en  = ~r.gating[GATE_UART_ZERO_BIT] & io_clk_en;
  assign conv_clk_en   = ~r.gating[GATE_CONVERTER_BIT] & ~deep;
  assign cpu_clk_en    = ~sleeping;
  assign io_clk_en     = ~sleeping | (mode == RPG_MODE_IDLE);

  // RULE5 mux blocked when gated
  assign comp_mux_allow = conv_clk_en;
  assign conv_active    = conv_on;
  assign conv_extended  = r.conv_ext;
  assign comp_active    = comp_on;
  // RULE8 brownout always on
  assign brownout_active = bod_en;
  // RULE9 reference on demand
  assign ref_active = bod_en | comp_on | conv_on;
  // RULE10 watchdog runs in sleep
  assign watchdog_active = r.analog[WDOG_EN_BIT];
  // RULE11 input buffers off
  assign input_buf_en = io_clk_en | conv_clk_en;
  assign wake_buf_en  = input_buf_en | wake_pin_needed;
  // RULE12 debug keeps oscillator
  assign main_osc_en = debug_enable_fuse | ~deep | (mode == RPG_MODE_STANDBY);

endmodule // rpg_reset_power_control

// ---- sim/rpg_reset_power_control_monitor.sv ----
`timescale 1ns/100ps
module rpg_rpc_monitor
  import rpg_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = 4
) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       clk_en,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       supply_low,
  input wire logic       reset_pin_n,
  input wire logic       watchdog_expired,
  input wire logic [2:0] brownout_level_fuses,
  input wire logic       debug_enable_fuse,
  input wire logic       io_reset_n,
  input wire logic       core_reset_n,
  input wire logic       conv_clk_en,
  input wire logic       serial_clk_en,
  input wire logic       comp_mux_allow,
  input wire logic       conv_active,
  input wire logic       ref_active,
  input wire logic       brownout_active,
  input wire logic       watchdog_active,
  input wire logic       main_osc_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic gw;
  assign gw = wr && clk_en && core_reset_n && addr == OFS_CLOCK_GATING;
  property p_conv_gate; gw && wdata[GATE_CONVERTER_BIT] |=> !conv_clk_en; endproperty
  a_conv_gate: assert property (p_conv_gate) else $error("converter clock not stopped");
  property p_serial_gate; gw && wdata[GATE_SERIAL_BIT] |=> !serial_clk_en; endproperty
  a_serial_gate: assert property (p_serial_gate) else $error("serial clock not stopped");
  property p_mux; gw && wdata[GATE_CONVERTER_BIT] |=> !comp_mux_allow; endproperty
  a_mux: assert property (p_mux) else $error("comparator mux usable while gated");
  property p_bod; brownout_level_fuses != BROWNOUT_OFF_CODE |-> brownout_active; endproperty
  a_bod: assert property (p_bod) else $error("brown-out detector off");
  property p_ref; conv_active || brownout_active |-> ref_active; endproperty
  a_ref: assert property (p_ref) else $error("reference off while needed");
  property p_debug; debug_enable_fuse |-> main_osc_en; endproperty
  a_debug: assert property (p_debug) else $error("main oscillator off with debug");
  property p_io; supply_low || !reset_pin_n |-> !io_reset_n; endproperty
  a_io: assert property (p_io) else $error("port reset not immediate");
  property p_stretch; $rose(io_reset_n) |=> (!core_reset_n) [*4]; endproperty
  a_stretch: assert property (p_stretch) else $error("internal reset not stretched");
  property p_supply; (supply_low && clk_en) [*3] |=> !core_reset_n; endproperty
  a_supply: assert property (p_supply) else $error("supply reset not held");
  property p_wdog; watchdog_expired && watchdog_active && clk_en |=> !core_reset_n; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog reset missing");
  c_release: cover property ($rose(core_reset_n));
  c_gate: cover property (gw && wdata[GATE_CONVERTER_BIT]);
  c_wdog: cover property (watchdog_expired && watchdog_active);
endmodule // rpg_rpc_monitor

bind rpg_reset_power_control rpg_rpc_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_mon (
  .clk, .rstn, .clk_en, .addr, .wdata, .wr, .supply_low, .reset_pin_n, .watchdog_expired,
  .brownout_level_fuses, .debug_enable_fuse, .io_reset_n, .core_reset_n, .conv_clk_en, .serial_clk_en,
  .comp_mux_allow, .conv_active, .ref_active, .brownout_active, .watchdog_active, .main_osc_en);

// ---- sim/rpg_reset_pin_model.sv ----
`timescale 1ns/100ps
module rpg_reset_pin_model #(
  parameter int MIN_LOW = 4
) (
  input wire logic       clk,         // board clock
  input wire logic       start,       // request one pulse
  input wire logic [7:0] low_cycles,  // requested low time
  output logic           reset_pin_n  // pin, pulled up when idle
);
  logic [7:0] cnt = 8'h00;
  always @(posedge clk) begin
    if (start)
      cnt <= (low_cycles < MIN_LOW) ? 8'(MIN_LOW) : low_cycles;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end
  assign reset_pin_n = (cnt == 8'h00);
endmodule // rpg_reset_pin_model

// ---- sim/rpg_reset_power_control_tb_top.sv ----
`timescale 1ns/100ps
module rpg_reset_power_control_tb_top;
  import rpg_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, wr = 1'b0, rd = 1'b0, pin_go = 1'b0;
  logic supply_low = 1'b0, watchdog_expired = 1'b0, supply_below_bot = 1'b0, reset_pin_n, wake_need = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, pin_len = 8'h00, rdata;
  logic [2:0] fuses = 3'h2, stage_clk_en;
  logic io_reset_n, core_reset_n, cpu_clk_en, io_clk_en, conv_clk_en, timer0_clk_en, timer1_clk_en;
  logic serial_clk_en, uart0_clk_en, comp_mux_allow, conv_active, conv_extended, comp_active;
  logic ref_active, brownout_active, watchdog_active, input_buf_en, wake_buf_en, main_osc_en;
  int n_errors = 0, samples_checked = 0;
  always #50 clk = ~clk;
  rpg_reset_power_control #(.TIMEOUT_CYCLES(4)) u_dut (
    .clk, .rstn, .clk_en, .addr, .wdata, .wr, .rd, .rdata, .supply_low, .reset_pin_n, .watchdog_expired,
    .supply_below_bot, .brownout_level_fuses(fuses), .debug_enable_fuse(1'b1), .wake_pin_needed(wake_need),
    .io_reset_n, .core_reset_n, .cpu_clk_en, .io_clk_en, .conv_clk_en, .timer0_clk_en, .timer1_clk_en,
    .serial_clk_en, .uart0_clk_en, .stage_clk_en, .comp_mux_allow, .conv_active, .conv_extended,
    .comp_active, .ref_active, .brownout_active, .watchdog_active, .input_buf_en, .wake_buf_en, .main_osc_en);
  rpg_reset_pin_model u_pin (.clk, .start(pin_go), .low_cycles(pin_len), .reset_pin_n);
  task automatic test_done;
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic wait_core;
    int k;
    k = 0;
    while (core_reset_n !== 1'b1 && k < 60) begin
      step(1);
      k++;
    end
    if (k == 60) begin
      n_errors++;
      test_done;
    end
  endtask
  function automatic logic [7:0] gates();
    return {stage_clk_en, timer1_clk_en, timer0_clk_en, serial_clk_en, uart0_clk_en, conv_clk_en};
  endfunction
  task automatic s_gating;
    chk(gates(), 8'hff);
    rd_reg(4'hf, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr_reg(OFS_CLOCK_GATING, 8'h01 << i);
      chk(gates(), ~(8'h01 << i));
      if (i == GATE_CONVERTER_BIT) chk(comp_mux_allow, 8'h00);
      rd_reg(OFS_CLOCK_GATING, 8'h01 << i);
    end
    wr_reg(OFS_CLOCK_GATING, 8'h00);
    clk_en <= 1'b0;
    wr_reg(OFS_CLOCK_GATING, 8'hff);
    chk(gates(), 8'hff);
    clk_en <= 1'b1;
  endtask
  task automatic s_sleep;
    wr_reg(OFS_ANALOG_CTRL, 8'h0b);
    step(1);
    chk(conv_extended, 8'h01);
    wr_reg(OFS_SLEEP_CTRL, 8'h05);
    chk({conv_active, comp_active, watchdog_active, brownout_active, ref_active, main_osc_en}, 8'h2f);
    chk({cpu_clk_en, io_clk_en}, 8'h00);
    wr_reg(OFS_ANALOG_CTRL, 8'h00);
    @(posedge clk);
    fuses <= 3'h7;
    step(1);
    chk({ref_active, input_buf_en, wake_buf_en, brownout_active}, 8'h02);
    @(posedge clk);
    wake_need <= 1'b0;
    step(1);
    chk(wake_buf_en, 8'h00);
    wr_reg(OFS_ANALOG_CTRL, 8'h02);
    wr_reg(OFS_SLEEP_CTRL, 8'h01);
    chk({comp_active, input_buf_en}, 8'h03);
    chk({cpu_clk_en, io_clk_en}, 8'h01);
    wr_reg(OFS_SLEEP_CTRL, 8'h00);
    @(posedge clk);
    fuses <= 3'h2;
    wake_need <= 1'b1;
  endtask
  task automatic s_pin;
    wr_reg(OFS_CLOCK_GATING, 8'hff);
    pin_go <= 1'b1;
    pin_len <= 8'h01;
    @(posedge clk);
    pin_go <= 1'b0;
    #1;
    chk(io_reset_n, 8'h00);
    step(4);
    chk(core_reset_n, 8'h00);
    wait_core;
    rd_reg(OFS_RESET_FLAGS, 8'h02);
    rd_reg(OFS_CLOCK_GATING, 8'h00);
  endtask
  task automatic s_sources;
    @(posedge clk);
    supply_low <= 1'b1;
    step(4);
    chk({io_reset_n, core_reset_n}, 8'h00);
    supply_low <= 1'b0;
    wait_core;
    rd_reg(OFS_RESET_FLAGS, 8'h01);
    wr_reg(OFS_ANALOG_CTRL, 8'h08);
    watchdog_expired <= 1'b1;
    @(posedge clk);
    watchdog_expired <= 1'b0;
    step(1);
    chk(core_reset_n, 8'h00);
    wait_core;
    fuses <= 3'h7;
    supply_below_bot <= 1'b1;
    step(4);
    chk({io_reset_n, core_reset_n}, 8'h03);
    fuses <= 3'h2;
    step(4);
    chk(core_reset_n, 8'h00);
    supply_below_bot <= 1'b0;
    wait_core;
    rd_reg(OFS_RESET_FLAGS, 8'h0d);
    wr_reg(OFS_RESET_FLAGS, 8'h00);
    rd_reg(OFS_RESET_FLAGS, 8'h00);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    step(1);
    wait_core;
    s_gating;
    s_sleep;
    s_pin;
    s_sources;
    test_done;
  end
endmodule // rpg_reset_power_control_tb_top
